// *** rtl/src_pkg.sv ***
`default_nettype none
package src_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned DEBOUNCE_NS     = 1_320_000;
  localparam int unsigned CORE_RELEASE_NS = 2_630_000;
  localparam int unsigned NOMEM_LOAD_NS   = 17_000;
  // Least times round up, the no-memory load bound rounds down
  localparam int unsigned DEBOUNCE_CYCLES =
    (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CORE_RELEASE_CYCLES =
    (CORE_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned NOMEM_LOAD_CYCLES = NOMEM_LOAD_NS / CLK_PERIOD_NS;
  localparam int unsigned HOT_HOLD_CYCLES   = 16;

  localparam int unsigned CNT_W = 10;
  typedef logic [CNT_W-1:0] src_cnt_type;
  localparam src_cnt_type NOMEM_LAST = src_cnt_type'(NOMEM_LOAD_CYCLES - 1);
  localparam src_cnt_type HOT_LAST   = src_cnt_type'(HOT_HOLD_CYCLES - 1);

  localparam logic [1:0] TS_RUN_LEN = 2'h2;

  localparam logic [11:0] BRIDGE_CTL_OFFSET = 12'h03c;
  localparam logic [11:0] MEM_STATUS_OFFSET = 12'h260;
  localparam int unsigned BC_LSB        = 16;
  localparam int unsigned BC_W          = 8;
  localparam int unsigned SBR_BIT       = 22;
  localparam int unsigned BC_BYTE       = 2;
  localparam int unsigned MEM_DATA_LSB  = 24;
  localparam int unsigned PRESENCE_LSB  = 16;
  localparam logic [BC_W-1:0] BC_RESET  = 8'h00;
  localparam logic [1:0] PRESENCE_NONE  = 2'h0;
  localparam logic [1:0] PRESENCE_FOUND = 2'h1;

  typedef enum logic [2:0] {
    ST_FUND,
    ST_STRAP,
    ST_LOAD_START,
    ST_LOAD_WAIT,
    ST_FILL,
    ST_NOMEM_WAIT,
    ST_RUN,
    ST_HOT
  } src_state_type;
endpackage
`default_nettype wire

// *** rtl/src_rst_if.sv ***
`default_nettype none
interface src_rst_if;
  logic core_rst;
  logic clk_gen_rst;
  logic debounce_done;
  modport seq (output core_rst, output clk_gen_rst, output debounce_done);
  modport ctl (input core_rst, input clk_gen_rst, input debounce_done);
endinterface
`default_nettype wire

// *** rtl/src_por_seq.sv ***
`default_nettype none
module src_por_seq #(
  parameter int unsigned DEBOUNCE_CYCLES     = src_pkg::DEBOUNCE_CYCLES,
  parameter int unsigned CORE_RELEASE_CYCLES = src_pkg::CORE_RELEASE_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic fundamental_reset_in_n_i,
  src_rst_if.seq    rif
);
  localparam int unsigned MAXC = (DEBOUNCE_CYCLES > CORE_RELEASE_CYCLES) ?
                                 DEBOUNCE_CYCLES : CORE_RELEASE_CYCLES;
  localparam int unsigned CW = $clog2(MAXC + 1);
  localparam logic [CW-1:0] DEB_LAST  = CW'(DEBOUNCE_CYCLES - 1);
  localparam logic [CW-1:0] CORE_LAST = CW'(CORE_RELEASE_CYCLES - 1);

  logic          pin_s1_q;
  logic          pin_s2_q;
  logic [CW-1:0] cnt_q;
  wire           deb_end  = pin_s2_q && !rif.debounce_done && (cnt_q == DEB_LAST);
  wire           core_end = rif.debounce_done && rif.core_rst && (cnt_q == CORE_LAST);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
    end else if (ce_i) begin
      pin_s1_q <= fundamental_reset_in_n_i;
      pin_s2_q <= pin_s1_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && !pin_s2_q)) begin
      cnt_q             <= '0;
      rif.debounce_done <= 1'b0;
      rif.core_rst      <= 1'b1;
      rif.clk_gen_rst   <= 1'b1;
    end else if (ce_i) begin
      if (deb_end) begin
        cnt_q             <= '0;
        rif.debounce_done <= 1'b1;
        rif.clk_gen_rst   <= 1'b0;
      end else if (core_end) begin
        rif.core_rst <= 1'b0;
      end else if (rif.core_rst) begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_CORE_AFTER_DEB: assert property ($fell(rif.core_rst) |-> rif.debounce_done)
    else $error("core reset released before debounce finished");
  AST_PIN_LOW_HOLDS: assert property (ce_i && !pin_s2_q |=>
    rif.core_rst && rif.clk_gen_rst && !rif.debounce_done)
    else $error("reset pin low did not hold resets");
endmodule
`default_nettype wire

// *** rtl/src_reset_ctrl.sv ***
// Functional notes
// - Fundamental reset restores everything and reloads memory
// - Two TS1 with hot bit start hot reset
// - Unexpected upstream DL_Down starts hot reset
// - Link down in L2 gives no hot reset
// - Loopback or disable training bits cause hot reset
// - Hot reset clears non-sticky state, reloads memory
// - Only fundamental reset resets clock logic
// - Hot reset reinitialises credits, empties queues
// - Hot reset propagates to transparent downstream ports
// - Upstream bus reset resets, hot-resets downstream ports
// - Isolated port emits no hot reset then
// - Upstream bus reset clears downstream registers only
// - Upstream stays up, downstream down and discarding
// - Downstream bus reset hot-resets that port only
// - Reset downstream port down, requests discarded
// - Others drain traffic, reinit credits for it
// - Memory present if status nonzero, copy it
// - Presence field reads 01b when memory found
// - Debounce released reset pin before use
// - Release core reset after further delay
// - Finish load quickly when no memory
// - Sample straps, then load, then train
`default_nettype none
module src_reset_ctrl #(
  parameter int unsigned NPORTS              = 6,
  parameter int unsigned PORT_W              = 3,
  parameter int unsigned LANE_CFG_W          = 8,
  parameter int unsigned DEBOUNCE_CYCLES     = src_pkg::DEBOUNCE_CYCLES,
  parameter int unsigned CORE_RELEASE_CYCLES = src_pkg::CORE_RELEASE_CYCLES
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  input  wire logic                  fundamental_reset_in_n_i,
  input  wire logic [3:0]            strap_upstream_port_i,
  input  wire logic [LANE_CFG_W-1:0] strap_lane_cfg_i,
  input  wire logic                  us_ts_valid_i,
  input  wire logic                  us_ts_is_ts2_i,
  input  wire logic                  us_ts_hot_reset_i,
  input  wire logic                  us_ts_loopback_i,
  input  wire logic                  us_ts_disable_i,
  input  wire logic                  us_dl_up_i,
  input  wire logic                  us_link_l2_i,
  input  wire logic [NPORTS-1:0]     isolated_port_i,
  input  wire logic                  cfg_wr_i,
  input  wire logic                  cfg_rd_i,
  input  wire logic [PORT_W-1:0]     cfg_port_i,
  input  wire logic [11:0]           cfg_addr_i,
  input  wire logic [31:0]           cfg_wdata_i,
  input  wire logic [3:0]            cfg_be_i,
  input  wire logic                  mem_status_valid_i,
  input  wire logic [7:0]            mem_status_data_i,
  input  wire logic                  mem_load_done_i,
  output logic                       core_rst_o,
  output logic                       clk_gen_rst_o,
  output logic                       sticky_rst_o,
  output logic                       nonsticky_clr_o,
  output logic                       hwinit_eval_o,
  output logic [NPORTS-1:0]          port_rst_o,
  output logic [NPORTS-1:0]          credit_init_o,
  output logic [NPORTS-1:0]          queue_flush_o,
  output logic [NPORTS-1:0]          ds_regs_rst_o,
  output logic [NPORTS-1:0]          tx_hot_reset_o,
  output logic [NPORTS-1:0]          dl_force_down_o,
  output logic                       mem_load_start_o,
  output logic                       link_train_en_o,
  output logic [3:0]                 upstream_port_sel_o,
  output logic [LANE_CFG_W-1:0]      lane_cfg_o,
  output logic [31:0]                cfg_rdata_o,
  output logic                       cfg_rvalid_o
);
  localparam logic [NPORTS-1:0] DS_MASK = {{(NPORTS-1){1'b1}}, 1'b0};
  localparam int unsigned SBR_POS = src_pkg::SBR_BIT - src_pkg::BC_LSB;

  function automatic logic [1:0] src_run_next(input logic [1:0] cnt, input logic hit);
    logic [1:0] nxt;
    nxt = 2'h0;
    if (hit) begin
      nxt = (cnt == src_pkg::TS_RUN_LEN) ? cnt : cnt + 2'h1;
    end
    return nxt;
  endfunction

  src_rst_if rif ();

  src_por_seq #(
    .DEBOUNCE_CYCLES    (DEBOUNCE_CYCLES),
    .CORE_RELEASE_CYCLES(CORE_RELEASE_CYCLES)
  ) u_por (
    .clk_i                   (clk_i),
    .rst_i                   (rst_i),
    .ce_i                    (ce_i),
    .fundamental_reset_in_n_i(fundamental_reset_in_n_i),
    .rif                     (rif)
  );

  src_pkg::src_state_type  st_q;
  src_pkg::src_state_type  st_d;
  src_pkg::src_cnt_type    cnt_q;
  logic [3:0]              ups_s1_q;
  logic [3:0]              ups_s2_q;
  logic [LANE_CFG_W-1:0]   lane_s1_q;
  logic [LANE_CFG_W-1:0]   lane_s2_q;
  logic                    straps_done_q;
  logic                    hot_flag_q;
  logic [1:0]              hot_cnt_q;
  logic [1:0]              ld_cnt_q;
  logic                    us_dl_up_q;
  logic [7:0]              mem_data_q;
  logic [1:0]              presence_q;
  logic [src_pkg::BC_W-1:0] bc_q [NPORTS];
  logic [NPORTS-1:0]       ds_sbr;

  wire fund   = rif.core_rst;
  wire run    = (st_q == src_pkg::ST_RUN);
  wire in_hot = (st_q == src_pkg::ST_HOT);
  wire us_sbr = bc_q[0][SBR_POS];

  // Training set runs
  wire        ts_hot_hit  = !us_ts_is_ts2_i && us_ts_hot_reset_i;
  wire        ts_ld_hit   = us_ts_loopback_i || us_ts_disable_i;
  wire [1:0]  hot_cnt_d   = us_ts_valid_i ? src_run_next(hot_cnt_q, ts_hot_hit) : hot_cnt_q;
  wire [1:0]  ld_cnt_d    = us_ts_valid_i ? src_run_next(ld_cnt_q, ts_ld_hit) : ld_cnt_q;
  wire        ts_hot_trig = (hot_cnt_d == src_pkg::TS_RUN_LEN) &&
                            (hot_cnt_q != src_pkg::TS_RUN_LEN);
  wire        ts_ld_trig  = (ld_cnt_d == src_pkg::TS_RUN_LEN) &&
                            (ld_cnt_q != src_pkg::TS_RUN_LEN);
  wire        dl_fall     = us_dl_up_q && !us_dl_up_i;
  wire        dl_down_trig = dl_fall && !us_link_l2_i;
  wire        hot_cause   = run && (ts_hot_trig || ts_ld_trig || dl_down_trig);

  // Per-port reset vectors
  wire [NPORTS-1:0] us_sbr_ports = (run && us_sbr) ? DS_MASK : '0;
  wire [NPORTS-1:0] sbr_ports    = run ? (us_sbr_ports | ds_sbr) : '0;
  wire [NPORTS-1:0] hold_all     = run ? '0 : '1;
  wire [NPORTS-1:0] hot_all      = in_hot ? '1 : '0;
  wire [NPORTS-1:0] tx_hot_d     = (in_hot ? (DS_MASK & ~isolated_port_i) : '0) |
                                   (us_sbr_ports & ~isolated_port_i) |
                                   (run ? ds_sbr : '0);

  // Register access
  wire              bc_addr  = (cfg_addr_i == src_pkg::BRIDGE_CTL_OFFSET);
  wire              ms_addr  = (cfg_addr_i == src_pkg::MEM_STATUS_OFFSET) &&
                               (cfg_port_i == '0);
  wire              port_ok  = (cfg_port_i < PORT_W'(NPORTS));
  wire [src_pkg::BC_W-1:0] bc_sel = port_ok ? bc_q[cfg_port_i] : src_pkg::BC_RESET;
  wire [31:0]       bc_word  = 32'(bc_sel) << src_pkg::BC_LSB;
  wire [31:0]       ms_word  = (32'(mem_data_q) << src_pkg::MEM_DATA_LSB) |
                               (32'(presence_q) << src_pkg::PRESENCE_LSB);
  wire [31:0]       rd_word  = bc_addr ? bc_word : (ms_addr ? ms_word : 32'h0000_0000);
  wire              wr_bc    = run && cfg_wr_i && bc_addr && cfg_be_i[src_pkg::BC_BYTE];
  wire [src_pkg::BC_W-1:0] bc_wdata = cfg_wdata_i[src_pkg::BC_LSB +: src_pkg::BC_W];

  for (genvar p = 0; p < NPORTS; p++) begin : g_bc
    logic wr_hit;
    logic clr_hit;
    assign wr_hit  = wr_bc && (cfg_port_i == PORT_W'(p));
    // Downstream copies are also cleared while the upstream bus reset is held
    assign clr_hit = fund || in_hot || ((p != 0) && run && us_sbr);
    if (p == 0) begin : g_us
      assign ds_sbr[p] = 1'b0;
    end else begin : g_ds
      assign ds_sbr[p] = bc_q[p][SBR_POS];
    end
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        bc_q[p] <= src_pkg::BC_RESET;
      end else if (ce_i) begin
        if (clr_hit) begin
          bc_q[p] <= src_pkg::BC_RESET;
        end else if (wr_hit) begin
          bc_q[p] <= bc_wdata;
        end
      end
    end
  end

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      src_pkg::ST_FUND:       st_d = src_pkg::ST_STRAP;
      src_pkg::ST_STRAP:      st_d = src_pkg::ST_LOAD_START;
      src_pkg::ST_LOAD_START: st_d = src_pkg::ST_LOAD_WAIT;
      src_pkg::ST_LOAD_WAIT: begin
        if (mem_status_valid_i) begin
          st_d = (mem_status_data_i != 8'h00) ? src_pkg::ST_FILL :
                                               src_pkg::ST_NOMEM_WAIT;
        end
      end
      src_pkg::ST_FILL:       st_d = mem_load_done_i ? src_pkg::ST_RUN : src_pkg::ST_FILL;
      src_pkg::ST_NOMEM_WAIT: st_d = (cnt_q == src_pkg::NOMEM_LAST) ? src_pkg::ST_RUN :
                                                                     src_pkg::ST_NOMEM_WAIT;
      src_pkg::ST_RUN:        st_d = hot_cause ? src_pkg::ST_HOT : src_pkg::ST_RUN;
      src_pkg::ST_HOT:        st_d = (cnt_q == src_pkg::HOT_LAST) ? src_pkg::ST_LOAD_START :
                                                                   src_pkg::ST_HOT;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ups_s1_q  <= '0;
      ups_s2_q  <= '0;
      lane_s1_q <= '0;
      lane_s2_q <= '0;
    end else if (ce_i) begin
      ups_s1_q  <= strap_upstream_port_i;
      ups_s2_q  <= ups_s1_q;
      lane_s1_q <= strap_lane_cfg_i;
      lane_s2_q <= lane_s1_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && fund)) begin
      st_q       <= src_pkg::ST_FUND;
      cnt_q      <= '0;
      hot_flag_q <= 1'b0;
    end else if (ce_i) begin
      st_q  <= st_d;
      cnt_q <= (st_d != st_q) ? '0 : cnt_q + src_pkg::src_cnt_type'(1);
      if (in_hot) begin
        hot_flag_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && (fund || in_hot))) begin
      hot_cnt_q  <= '0;
      ld_cnt_q   <= '0;
      us_dl_up_q <= 1'b0;
    end else if (ce_i) begin
      hot_cnt_q  <= hot_cnt_d;
      ld_cnt_q   <= ld_cnt_d;
      us_dl_up_q <= us_dl_up_i;
    end
  end

  // Port configuration survives hot reset: straps are taken only after fundamental reset
  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && fund)) begin
      straps_done_q       <= 1'b0;
      upstream_port_sel_o <= '0;
      lane_cfg_o          <= '0;
      mem_data_q          <= 8'h00;
      presence_q          <= src_pkg::PRESENCE_NONE;
    end else if (ce_i) begin
      if (st_q == src_pkg::ST_STRAP && !hot_flag_q) begin
        straps_done_q       <= 1'b1;
        upstream_port_sel_o <= ups_s2_q;
        lane_cfg_o          <= lane_s2_q;
      end
      if (st_q == src_pkg::ST_LOAD_WAIT && mem_status_valid_i) begin
        mem_data_q <= mem_status_data_i;
        presence_q <= (mem_status_data_i != 8'h00) ? src_pkg::PRESENCE_FOUND :
                                                     src_pkg::PRESENCE_NONE;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_rst_o       <= 1'b1;
      clk_gen_rst_o    <= 1'b1;
      sticky_rst_o     <= 1'b1;
      nonsticky_clr_o  <= 1'b0;
      hwinit_eval_o    <= 1'b0;
      port_rst_o       <= '1;
      credit_init_o    <= '1;
      queue_flush_o    <= '0;
      ds_regs_rst_o    <= '0;
      tx_hot_reset_o   <= '0;
      dl_force_down_o  <= '0;
      mem_load_start_o <= 1'b0;
      link_train_en_o  <= 1'b0;
      cfg_rdata_o      <= 32'h0000_0000;
      cfg_rvalid_o     <= 1'b0;
    end else if (ce_i) begin
      core_rst_o       <= rif.core_rst;
      clk_gen_rst_o    <= rif.clk_gen_rst;
      sticky_rst_o     <= fund;
      nonsticky_clr_o  <= in_hot;
      hwinit_eval_o    <= (st_q != src_pkg::ST_RUN) && (st_d == src_pkg::ST_RUN) &&
                          !hot_flag_q;
      port_rst_o       <= hold_all | sbr_ports;
      credit_init_o    <= hold_all | sbr_ports;
      queue_flush_o    <= hot_all | sbr_ports;
      ds_regs_rst_o    <= us_sbr_ports;
      tx_hot_reset_o   <= tx_hot_d;
      dl_force_down_o  <= sbr_ports;
      mem_load_start_o <= (st_q == src_pkg::ST_LOAD_START);
      link_train_en_o  <= run && !fund;
      cfg_rdata_o      <= cfg_rd_i ? rd_word : 32'h0000_0000;
      cfg_rvalid_o     <= cfg_rd_i;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_run_step;
    ce_i && run && !fund;
  endsequence
  sequence s_hot_second;
    s_run_step ##0 us_ts_valid_i && ts_hot_hit && (hot_cnt_q == 2'h1);
  endsequence
  sequence s_ld_second;
    s_run_step ##0 us_ts_valid_i && ts_ld_hit && (ld_cnt_q == 2'h1);
  endsequence

  AST_TS_HOT: assert property (s_hot_second |=> st_q == src_pkg::ST_HOT)
    else $error("second hot reset training set ignored");
  AST_DL_DOWN: assert property (s_run_step ##0 dl_fall && !us_link_l2_i |=>
    st_q == src_pkg::ST_HOT)
    else $error("upstream link loss did not start hot reset");
  AST_L2_NO_HOT: assert property (dl_fall && us_link_l2_i && !ts_hot_trig && !ts_ld_trig
    |-> !hot_cause)
    else $error("hot reset raised for link loss in L2");
  AST_TS_LOOP: assert property (s_ld_second |=> st_q == src_pkg::ST_HOT)
    else $error("loopback or disable training set ignored");
  AST_HOT_OUT: assert property (ce_i && in_hot && !fund |=>
    (&port_rst_o) && (&credit_init_o) && (&queue_flush_o) && nonsticky_clr_o)
    else $error("hot reset did not reinitialise ports and queues");
  AST_HOT_PROP: assert property (ce_i && in_hot && !fund |=>
    tx_hot_reset_o == (DS_MASK & ~$past(isolated_port_i)))
    else $error("hot reset not propagated to transparent ports");
  AST_ISO_QUIET: assert property (s_run_step ##0 us_sbr |=>
    (tx_hot_reset_o & $past(isolated_port_i) & ~$past(ds_sbr)) == '0)
    else $error("isolated port emitted hot reset");
  AST_US_SBR: assert property (s_run_step ##0 us_sbr |=>
    ds_regs_rst_o == DS_MASK && !dl_force_down_o[0] && !mem_load_start_o)
    else $error("upstream bus reset scope wrong");
  AST_DS_SBR: assert property (s_run_step ##0 !us_sbr |=>
    dl_force_down_o == $past(ds_sbr) && credit_init_o == $past(ds_sbr))
    else $error("downstream bus reset scope wrong");
  AST_PRESENCE: assert property (ce_i && !fund && st_q == src_pkg::ST_LOAD_WAIT &&
    mem_status_valid_i && mem_status_data_i != 8'h00 |=>
    presence_q == src_pkg::PRESENCE_FOUND && mem_data_q == $past(mem_status_data_i))
    else $error("memory presence not recorded");
  AST_TRAIN_ORDER: assert property (link_train_en_o |-> straps_done_q)
    else $error("training enabled before straps sampled");
endmodule
`default_nettype wire

// *** verif/src_far_model.sv ***
`default_nettype none
module src_far_model (
  input  wire logic       clk_i,
  input  wire logic       load_start_i,
  input  wire logic [7:0] status_byte_i,
  input  wire logic       slow_i,
  output var logic        valid_o,
  output var logic  [7:0] data_o,
  output var logic        done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_q = 0;
  int done_q = 0;
  initial begin
    valid_o = 1'b0;
    data_o  = 8'h00;
    done_o  = 1'b0;
  end
  // Status answer comes fast or slow; the bus toggles while not valid
  always @(posedge clk_i) begin
    valid_o <= 1'b0;
    data_o  <= ~data_o;
    if (wait_q > 0) wait_q <= wait_q - 1;
    if (done_q > 0) done_q <= done_q - 1;
    if (wait_q == 1) begin
      valid_o <= 1'b1;
      data_o  <= status_byte_i;
      if (status_byte_i != 8'h00) done_q <= 6;
    end
    if (done_q == 1) done_o <= 1'b1;
    if (load_start_i) begin
      wait_q <= slow_i ? 40 : 3;
      done_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** verif/tb_switch_reset_control.sv ***
`default_nettype none
module tb_switch_reset_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, fundamental_reset_in_n_i = 1'b0;
  logic        us_ts_valid_i = 1'b0, us_ts_is_ts2_i, us_ts_hot_reset_i, us_ts_loopback_i;
  logic        us_ts_disable_i, us_dl_up_i = 1'b1, us_link_l2_i = 1'b0, slow = 1'b0;
  logic        cfg_wr_i = 1'b0, cfg_rd_i = 1'b0, mem_status_valid_i, mem_load_done_i;
  logic [3:0]  strap_upstream_port_i = 4'h5, cfg_be_i = 4'hf, upstream_port_sel_o;
  logic [7:0]  strap_lane_cfg_i = 8'h3c, mbyte = 8'ha5, mem_status_data_i, lane_cfg_o;
  logic [5:0]  isolated_port_i = 6'h04, port_rst_o, credit_init_o, queue_flush_o;
  logic [5:0]  ds_regs_rst_o, tx_hot_reset_o, dl_force_down_o;
  logic [2:0]  cfg_port_i = 3'h0;
  logic [11:0] cfg_addr_i = 12'h000;
  logic [31:0] cfg_wdata_i = 32'h0000_0000, cfg_rdata_o;
  logic [32:0] rq;
  logic        core_rst_o, clk_gen_rst_o, sticky_rst_o, nonsticky_clr_o, hwinit_eval_o;
  logic        mem_load_start_o, link_train_en_o, cfg_rvalid_o;
  logic [3:0]  cause [4] = '{4'h4, 4'h2, 4'ha, 4'h9};
  int          err_total = 0, tests_run = 0, cyc = 0, ms_cnt = 0, hw_cnt = 0, n, ms0;

  src_reset_ctrl #(.DEBOUNCE_CYCLES(8), .CORE_RELEASE_CYCLES(16)) dut (
    .clk_i, .rst_i, .ce_i, .fundamental_reset_in_n_i, .strap_upstream_port_i,
    .strap_lane_cfg_i, .us_ts_valid_i, .us_ts_is_ts2_i, .us_ts_hot_reset_i,
    .us_ts_loopback_i, .us_ts_disable_i, .us_dl_up_i, .us_link_l2_i, .isolated_port_i,
    .cfg_wr_i, .cfg_rd_i, .cfg_port_i, .cfg_addr_i, .cfg_wdata_i, .cfg_be_i,
    .mem_status_valid_i, .mem_status_data_i, .mem_load_done_i, .core_rst_o,
    .clk_gen_rst_o, .sticky_rst_o, .nonsticky_clr_o, .hwinit_eval_o, .port_rst_o,
    .credit_init_o, .queue_flush_o, .ds_regs_rst_o, .tx_hot_reset_o, .dl_force_down_o,
    .mem_load_start_o, .link_train_en_o, .upstream_port_sel_o, .lane_cfg_o,
    .cfg_rdata_o, .cfg_rvalid_o
  );
  src_far_model far (
    .clk_i, .load_start_i(mem_load_start_o), .status_byte_i(mbyte), .slow_i(slow),
    .valid_o(mem_status_valid_i), .data_o(mem_status_data_i), .done_o(mem_load_done_i)
  );

  initial forever #12.5 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    cyc++;
    if (mem_load_start_o === 1'b1) ms_cnt++;
    if (hwinit_eval_o === 1'b1) hw_cnt++;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask
  // One config access; read answer is caught in the cycle after the take
  task automatic cfg(input logic w, input logic [2:0] p, input logic [11:0] a,
                     input logic [31:0] d);
    {cfg_wr_i, cfg_rd_i, cfg_port_i, cfg_addr_i, cfg_wdata_i} = {w, !w, p, a, d};
    tick(1);
    rq = {cfg_rvalid_o, cfg_rdata_o};
    {cfg_wr_i, cfg_rd_i} = 2'h0;
    tick(1);
  endtask
  task automatic rdchk(input logic [2:0] p, input logic [11:0] a, input logic [31:0] e);
    cfg(1'b0, p, a, 32'h0000_0000);
    chk(rq, {1'b1, e});
  endtask
  task automatic wait_train();
    for (n = 0; n < 1000 && link_train_en_o !== 1'b1; n++) tick(1);
  endtask
  task automatic hot_chk();
    for (int k = 0; k < 6 && nonsticky_clr_o !== 1'b1; k++) tick(1);
    chk({port_rst_o, credit_init_o, queue_flush_o}, {6'h3f, 6'h3f, 6'h3f});
    chk(tx_hot_reset_o, 6'h3a);
    chk({clk_gen_rst_o, link_train_en_o, nonsticky_clr_o}, 3'h1);
    for (int k = 0; k < 40 && mem_load_start_o !== 1'b1; k++) tick(1);
  endtask

  initial begin
    tick(2);
    chk({core_rst_o, clk_gen_rst_o, sticky_rst_o, port_rst_o}, {3'h7, 6'h3f});
    rst_i = 1'b0;
    tick(3);
    fundamental_reset_in_n_i = 1'b1;
    wait_train();
    chk({upstream_port_sel_o, lane_cfg_o, 4'(hw_cnt)}, {4'h5, 8'h3c, 4'h1});
    rdchk(3'h0, 12'h260, 32'ha501_0000);
    rdchk(3'h0, 12'h100, 32'h0000_0000);
    cfg(1'b1, 3'h3, 12'h03c, 32'h0001_0000);
    ms0 = ms_cnt;
    cfg(1'b1, 3'h0, 12'h03c, 32'h0040_0000);
    chk({ds_regs_rst_o, tx_hot_reset_o, port_rst_o}, {6'h3e, 6'h3a, 6'h3e});
    chk({dl_force_down_o, link_train_en_o}, {6'h3e, 1'b1});
    rdchk(3'h3, 12'h03c, 32'h0000_0000);
    rdchk(3'h0, 12'h03c, 32'h0040_0000);
    cfg(1'b1, 3'h0, 12'h03c, 32'h0000_0000);
    chk({ds_regs_rst_o, 32'(ms_cnt - ms0)}, 40'h0);
    cfg(1'b1, 3'h3, 12'h03c, 32'h0001_0000);
    cfg(1'b1, 3'h2, 12'h03c, 32'h0040_0000);
    chk({tx_hot_reset_o, dl_force_down_o, port_rst_o}, {6'h04, 6'h04, 6'h04});
    chk({credit_init_o, queue_flush_o, ds_regs_rst_o}, {6'h04, 6'h04, 6'h00});
    rdchk(3'h2, 12'h03c, 32'h0040_0000);
    cfg_be_i = 4'hb;
    cfg(1'b1, 3'h3, 12'h03c, 32'h0000_0000);
    cfg_be_i = 4'hf;
    rdchk(3'h3, 12'h03c, 32'h0001_0000);
    cfg(1'b1, 3'h2, 12'h03c, 32'h0000_0000);
    // A non-matching set between two hot sets breaks the run
    {us_ts_is_ts2_i, us_ts_hot_reset_i, us_ts_loopback_i, us_ts_disable_i} = 4'h4;
    us_ts_valid_i = 1'b1;
    tick(1);
    us_ts_hot_reset_i = 1'b0;
    tick(1);
    us_ts_hot_reset_i = 1'b1;
    tick(1);
    us_ts_valid_i = 1'b0;
    tick(4);
    chk({nonsticky_clr_o, link_train_en_o}, 2'h1);
    {us_link_l2_i, us_dl_up_i} = 2'h2;
    tick(4);
    chk({nonsticky_clr_o, link_train_en_o}, 2'h1);
    us_dl_up_i = 1'b1;
    tick(1);
    us_link_l2_i = 1'b0;
    for (int i = 0; i < 5; i++) begin
      slow = i[0];
      mbyte = (i == 4) ? 8'h00 : 8'h5a;
      cfg(1'b1, 3'h3, 12'h03c, 32'h0001_0000);
      ms0 = ms_cnt;
      {us_ts_is_ts2_i, us_ts_hot_reset_i, us_ts_loopback_i, us_ts_disable_i} = cause[i % 4];
      {us_ts_valid_i, us_dl_up_i} = (i < 4) ? 2'h3 : 2'h0;
      tick(2);
      {us_ts_valid_i, us_dl_up_i} = 2'h1;
      hot_chk();
      wait_train();
      chk({32'(ms_cnt - ms0), 1'(n <= 690)}, {32'h1, 1'b1});
      rdchk(3'h3, 12'h03c, 32'h0000_0000);
      rdchk(3'h0, 12'h260, {mbyte, 6'h00, (i == 4) ? 2'h0 : 2'h1, 16'h0000});
    end
    chk(hw_cnt, 1);
    cfg(1'b1, 3'h3, 12'h03c, 32'h0001_0000);
    fundamental_reset_in_n_i = 1'b0;
    tick(5);
    chk({core_rst_o, clk_gen_rst_o, sticky_rst_o, link_train_en_o}, 4'he);
    fundamental_reset_in_n_i = 1'b1;
    // Clock enable low freezes the pin sync and delay counters
    ce_i = 1'b0;
    tick(10);
    chk({core_rst_o, link_train_en_o}, 2'h2);
    ce_i = 1'b1;
    for (n = 0; n < 60 && core_rst_o !== 1'b0; n++) tick(1);
    chk({1'(n >= 24), 1'(n <= 32)}, 2'h3);
    wait_train();
    chk(hw_cnt, 2);
    rdchk(3'h3, 12'h03c, 32'h0000_0000);
    final_report();
  end
endmodule
`default_nettype wire
